// [hdl/psb_bus_cycle.sv]
// System bus cycle engine for expansion and peripheral interface buses
`timescale 1ns/1ps
`default_nettype none
`include "psb_defs.svh"
module psb_bus_cycle
  import psb_pkg::*;
#(
  parameter int PI_TIMEOUT = `PSB_PI_TIMEOUT
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        req_valid,
  input  wire logic [23:0] req_addr,
  input  wire logic        req_write,
  input  wire logic        req_mem,
  input  wire logic [1:0]  req_be,
  input  wire logic [15:0] req_wdata,
  input  wire logic [23:0] disp_base,
  input  wire logic [23:0] disp_mask,
  input  wire logic [23:0] flash_base,
  input  wire logic [23:0] flash_mask,
  output logic             req_ready,
  output logic             rsp_done,
  output logic             rsp_timeout,
  output logic [15:0]      rsp_rdata,
  input  wire logic        expansion_double_osc,
  output logic             bus_clk_out,
  output logic [19:0]      sa_out,
  output logic             sa_lo_oe,
  input  wire logic [16:0] sa_lo_in,
  output logic [16:0]      dma_addr,
  output logic [23:17]     la_out,
  output logic             sbhe_n,
  output logic [15:0]      sd_out,
  output logic             sd_oe,
  input  wire logic [15:0] sd_in,
  input  wire logic        dma_active,
  output logic             periph_cycle_start_n,
  output logic             periph_write_not_read,
  output logic             periph_mem_not_io,
  output logic             periph_cmd_n,
  input  wire logic        periph_ready_n,
  output logic             display_region_select_n,
  output logic             flash_disk_select_n,
  output logic             boot_rom_select_n,
  input  wire logic        boot_rom_width_strap,
  output logic             memr_n,
  output logic             memw_n,
  output logic             ior_n,
  output logic             iow_n,
  input  wire logic        memcs16_n,
  input  wire logic        iocs16_n,
  input  wire logic        zero_wait_request_n
);

  if (PI_TIMEOUT < 2 || PI_TIMEOUT > 65535) begin : g_bad_timeout
    $error("PI_TIMEOUT out of range");
  end

  // Two-flop synchronisers for every pin input
  logic        osc_s1, osc_s2, osc_s3;
  logic        rdy_s1, rdy_s2, m16_s1, m16_s2, i16_s1, i16_s2;
  logic        zw_s1, zw_s2, strap_s1, strap_s2, dma_s1, dma_s2;
  logic [15:0] sd_s1, sd_s2;
  logic [16:0] sa_s1, sa_s2;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {osc_s1, osc_s2, osc_s3} <= 3'h0;
      {rdy_s1, rdy_s2, m16_s1, m16_s2, i16_s1, i16_s2} <= 6'h3F;
      {zw_s1, zw_s2, strap_s1, strap_s2} <= 4'hF;
      {dma_s1, dma_s2} <= 2'h0;
      {sd_s1, sd_s2} <= 32'h0;
      {sa_s1, sa_s2} <= 34'h0;
    end else begin
      {osc_s1, osc_s2, osc_s3} <= {expansion_double_osc, osc_s1, osc_s2};
      {rdy_s1, rdy_s2} <= {periph_ready_n, rdy_s1};
      {m16_s1, m16_s2} <= {memcs16_n, m16_s1};
      {i16_s1, i16_s2} <= {iocs16_n, i16_s1};
      {zw_s1, zw_s2} <= {zero_wait_request_n, zw_s1};
      {strap_s1, strap_s2} <= {boot_rom_width_strap, strap_s1};
      {dma_s1, dma_s2} <= {dma_active, dma_s1};
      {sd_s1, sd_s2} <= {sd_in, sd_s1};
      {sa_s1, sa_s2} <= {sa_lo_in, sa_s1};
    end
  end

  // Bus clock toggles on each oscillator rise; tick marks its rising edge
  logic osc_rise, bus_tick;
  assign osc_rise = osc_s2 & ~osc_s3;
  assign bus_tick = osc_rise & ~bus_clk_out;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) bus_clk_out <= 1'b0;
    else if (osc_rise) bus_clk_out <= ~bus_clk_out; // R10
  end

  // Region decode of the incoming request
  logic hit_disp, hit_flash, hit_rom, to_pi;
  assign hit_disp  = req_mem && ((req_addr ^ disp_base) & disp_mask) == 24'h000000;
  assign hit_flash = req_mem && ((req_addr ^ flash_base) & flash_mask) == 24'h000000;
  assign hit_rom   = req_mem && ((req_addr ^ `PSB_ROM_BASE) & `PSB_ROM_MASK) == 24'h000000;
  assign to_pi     = hit_disp | hit_flash;

  psb_state_e  state_q;
  logic        write_q, rom_q, mem_q, w16_q, zw_q;
  logic [2:0]  bcnt_q, len_q;
  logic [15:0] tcnt_q;
  logic        pi_end, pi_tmo, isa_end;
  logic [2:0]  len_now;
  logic        w16_now, zw_now;

  // Width and length chosen from inputs seen at the first bus clock
  always_comb begin
    if (rom_q) w16_now = strap_s2;              // R5
    else if (mem_q) w16_now = ~m16_s2;
    else w16_now = ~i16_s2;                     // R14
    zw_now = ~zw_s2;
    if (w16_now) len_now = zw_now ? `PSB_LEN_16_ZW : `PSB_LEN_16_STD; // R12
    else len_now = zw_now ? `PSB_LEN_8_ZW : `PSB_LEN_8_STD;           // R13
  end

  assign pi_tmo  = tcnt_q == 16'(PI_TIMEOUT - 1);
  assign pi_end  = state_q == PSB_PI_CMD && (~rdy_s2 || pi_tmo);   // R4
  assign isa_end = state_q == PSB_ISA_CMD && bus_tick && bcnt_q != 3'h0
                   && bcnt_q + 3'h1 == len_q;

  // Cycle sequencer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) state_q <= PSB_IDLE;
    else begin
      case (state_q)
        PSB_IDLE: begin
          if (req_valid) state_q <= to_pi ? PSB_PI_START : PSB_ISA_CMD;
        end
        PSB_PI_START: state_q <= PSB_PI_CMD;
        PSB_PI_CMD: begin
          if (pi_end) state_q <= PSB_DONE;
        end
        PSB_ISA_CMD: begin
          if (isa_end) state_q <= PSB_DONE;
        end
        default: state_q <= PSB_IDLE;
      endcase
    end
  end

  // Bus clock count and the latched width and length
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bcnt_q <= 3'h0;
      len_q  <= `PSB_LEN_8_STD;
      w16_q  <= 1'b0;
      zw_q   <= 1'b0;
    end else if (state_q != PSB_ISA_CMD) bcnt_q <= 3'h0;
    else if (bus_tick) begin
      bcnt_q <= bcnt_q + 3'h1;
      if (bcnt_q == 3'h0) begin               // R15
        len_q <= len_now;
        w16_q <= w16_now;
        zw_q  <= zw_now;
      end
    end
  end

  // Timeout counter for peripheral interface cycles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) tcnt_q <= 16'h0;
    else if (state_q == PSB_PI_CMD) tcnt_q <= tcnt_q + 16'h1;
    else tcnt_q <= 16'h0;
  end

  // Address, type and selects load together as a cycle is taken
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sa_out <= 20'h0;
      la_out <= 7'h0;
      sbhe_n <= 1'b1;
      sd_out <= 16'h0;
      write_q <= 1'b0;
      mem_q <= 1'b0;
      rom_q <= 1'b0;
      periph_write_not_read <= 1'b0;
      periph_mem_not_io <= 1'b0;
      display_region_select_n <= 1'b1;
      flash_disk_select_n <= 1'b1;
      boot_rom_select_n <= 1'b1;
    end else if (state_q == PSB_IDLE && req_valid) begin
      sa_out <= req_addr[19:0];
      la_out <= req_addr[23:17];
      sbhe_n <= ~req_be[1];                   // R8
      sd_out <= req_wdata;
      write_q <= req_write;
      mem_q <= req_mem;
      rom_q <= hit_rom;
      periph_write_not_read <= req_write;     // R2
      periph_mem_not_io <= req_mem;           // R3
      display_region_select_n <= ~hit_disp;   // R11
      flash_disk_select_n <= ~(hit_flash & ~hit_disp); // Display wins over flash
      boot_rom_select_n <= ~hit_rom;          // R6
    end else if (state_q == PSB_DONE) begin
      sbhe_n <= 1'b1;
      display_region_select_n <= 1'b1;
      flash_disk_select_n <= 1'b1;
      boot_rom_select_n <= 1'b1;
    end
  end

  // Strobes, data drive and answer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      periph_cycle_start_n <= 1'b1;
      periph_cmd_n <= 1'b1;
      {memr_n, memw_n, ior_n, iow_n} <= 4'hF;
      sd_oe <= 1'b0;
      rsp_done <= 1'b0;
      rsp_timeout <= 1'b0;
      rsp_rdata <= 16'h0;
      req_ready <= 1'b0;
    end else begin
      // Start goes low on the same edge that loads address and selects
      periph_cycle_start_n <= ~(state_q == PSB_IDLE && req_valid && to_pi); // R1
      periph_cmd_n <= ~((state_q == PSB_PI_START) || (state_q == PSB_PI_CMD && !pi_end));
      if (state_q == PSB_IDLE && req_valid && !to_pi) begin
        memr_n <= ~(req_mem & ~req_write);
        memw_n <= ~(req_mem & req_write);
        ior_n  <= ~(~req_mem & ~req_write);
        iow_n  <= ~(~req_mem & req_write);
      end else if (isa_end) {memr_n, memw_n, ior_n, iow_n} <= 4'hF;
      sd_oe <= (state_q == PSB_IDLE && req_valid && req_write)
               || (sd_oe && state_q != PSB_DONE);  // R9
      rsp_done <= pi_end | isa_end;
      rsp_timeout <= pi_end & rdy_s2;
      if ((pi_end | isa_end) && !write_q) rsp_rdata <= sd_s2;
      req_ready <= (state_q == PSB_IDLE && !req_valid) || state_q == PSB_DONE;
    end
  end

  // Lower address lines turn round while a DMA or master owns them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sa_lo_oe <= 1'b0;
      dma_addr <= 17'h0;
    end else begin
      sa_lo_oe <= ~dma_s2;                    // R7
      if (dma_s2) dma_addr <= sa_s2;
    end
  end

  property p_start_valid;
    @(posedge mclk) disable iff (!resetn)
      !periph_cycle_start_n |-> state_q == PSB_PI_START
        && (!display_region_select_n || !flash_disk_select_n);
  endproperty
  a_start_valid: assert property (p_start_valid) else $error("start without select"); // R1

  property p_pi_dir;
    @(posedge mclk) disable iff (!resetn)
      (state_q == PSB_PI_CMD) |-> sd_oe == periph_write_not_read;
  endproperty
  a_pi_dir: assert property (p_pi_dir) else $error("data drive disagrees with direction"); // R2

  property p_pi_end;
    @(posedge mclk) disable iff (!resetn)
      $rose(periph_cmd_n) && !rsp_timeout |-> $past(rdy_s2) == 1'b0;
  endproperty
  a_pi_end: assert property (p_pi_end) else $error("cycle ended without ready"); // R4

  property p_rom_sel;
    @(posedge mclk) disable iff (!resetn)
      !boot_rom_select_n |-> {la_out, sa_out[16]} == 8'(`PSB_ROM_BASE >> 16);
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("rom select outside rom"); // R6

  property p_dma_float;
    @(posedge mclk) disable iff (!resetn)
      dma_s2 |=> !sa_lo_oe;
  endproperty
  a_dma_float: assert property (p_dma_float) else $error("address driven during dma"); // R7

  property p_div;
    @(posedge mclk) disable iff (!resetn)
      (bus_clk_out != $past(bus_clk_out)) |-> $past(osc_rise);
  endproperty
  a_div: assert property (p_div) else $error("bus clock moved without osc edge"); // R10

  property p_len;
    @(posedge mclk) disable iff (!resetn)
      isa_end |-> bcnt_q + 3'h1 == (w16_q ? (zw_q ? `PSB_LEN_16_ZW : `PSB_LEN_16_STD)
                                          : (zw_q ? `PSB_LEN_8_ZW : `PSB_LEN_8_STD));
  endproperty
  a_len: assert property (p_len) else $error("wrong cycle length"); // R12

  property p_rom_width;
    @(posedge mclk) disable iff (!resetn)
      (state_q == PSB_ISA_CMD && bus_tick && bcnt_q == 3'h0 && rom_q) |=> w16_q == $past(strap_s2);
  endproperty
  a_rom_width: assert property (p_rom_width) else $error("rom width not from strap"); // R5

endmodule : psb_bus_cycle
`default_nettype wire

// [hdl/psb_defs.svh]
// Constants for the system bus cycle engine
// Notes on behaviour
// R1: Start strobe only while address, type, selects valid
// R2: Direction high for write, low for read
// R3: Space type high for memory, low for I/O
// R4: Peripheral cycle waits for ready or timeout
// R5: Boot ROM width follows strap, high means 16-bit
// R6: Boot ROM select low on boot ROM access
// R7: Lower address lines are inputs during DMA
// R8: Byte-high enable low when upper lane carries data
// R9: One shared 16-bit data bus, driven on writes
// R10: Bus clock is double-rate oscillator divided by two
// R11: Display select low inside programmed display space
// R12: 16-bit cycle three bus clocks, two on zero-wait
// R13: 8-bit cycle six bus clocks, three on zero-wait
// R14: I/O cycle 8-bit unless 16-bit select low
// R15: Sample width and zero-wait at first bus clock
`ifndef PSB_DEFS_SVH
`define PSB_DEFS_SVH
`define PSB_ROM_BASE     24'h0F0000
`define PSB_ROM_MASK     24'hFF0000
`define PSB_LEN_16_STD   3'h3
`define PSB_LEN_16_ZW    3'h2
`define PSB_LEN_8_STD    3'h6
`define PSB_LEN_8_ZW     3'h3
`define PSB_PI_TIMEOUT   64
`endif

// [hdl/psb_pkg.sv]
// Types for the system bus cycle engine
package psb_pkg;
  typedef enum logic [2:0] {
    PSB_IDLE,
    PSB_PI_START,
    PSB_PI_CMD,
    PSB_ISA_CMD,
    PSB_DONE
  } psb_state_e;
endpackage : psb_pkg

// [sim/psb_far_model.sv]
// Far-side peripheral bus device model
`timescale 1ns/1ps
`default_nettype none
module psb_far_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        periph_cmd_n,
  input  wire logic        periph_write_not_read,
  input  wire logic [3:0]  ready_dly,
  input  wire logic        ready_off,
  input  wire logic [15:0] read_word,
  output logic             periph_ready_n,
  output logic [15:0]      sd_in
);
  logic [3:0] wait_q;
  // Ready after ready_dly waits; data toggles outside a read so nothing stale passes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wait_q         <= 4'h0;
      periph_ready_n <= 1'b1;
      sd_in          <= 16'h5A5A;
    end else begin
      wait_q         <= periph_cmd_n ? 4'h0 : wait_q + 4'h1;
      periph_ready_n <= periph_cmd_n | ready_off | (wait_q < ready_dly);
      sd_in          <= (!periph_cmd_n && !periph_write_not_read) ? read_word : ~sd_in;
    end
  end
endmodule : psb_far_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the system bus cycle engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0, resetn = 1'b0, expansion_double_osc = 1'b0, ready_off = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0, req_mem = 1'b0, dma_active = 1'b0;
  logic        boot_rom_width_strap = 1'b1, memcs16_n = 1'b1, iocs16_n = 1'b1;
  logic        zero_wait_request_n = 1'b1, pb, act;
  logic [1:0]  req_be = 2'h0;
  logic [3:0]  ready_dly = 4'h2;
  logic [15:0] req_wdata = 16'h0000, read_word = 16'h0000, sd_in, sd_out, rsp_rdata;
  logic [16:0] sa_lo_in = 17'h00000, dma_addr;
  logic [23:0] req_addr = 24'h000000, disp_base = 24'h0A0000, disp_mask = 24'hFE0000;
  logic [23:0] flash_base = 24'hD00000, flash_mask = 24'hFF0000;
  logic        periph_ready_n, periph_cycle_start_n, periph_write_not_read, periph_mem_not_io;
  logic        periph_cmd_n, display_region_select_n, flash_disk_select_n, boot_rom_select_n;
  logic        sbhe_n, sd_oe, req_ready, rsp_done, rsp_timeout, bus_clk_out, sa_lo_oe;
  logic        memr_n, memw_n, ior_n, iow_n, s_start, s_wr, s_mem, s_disp, s_flash, s_rom;
  logic        s_sbhe, s_sd, s_nsel;
  logic [3:0]  s_strb;
  logic [19:0] sa_out;
  logic [23:17] la_out;
  logic [23:0] s_addr;
  int          miscompares = 0, num_checks = 0, n_rise = 0;
  // Oscillator offset from the main clock so the two never share an edge
  always #50 mclk = ~mclk;
  initial #37 forever #250 expansion_double_osc = ~expansion_double_osc;
  psb_bus_cycle #(.PI_TIMEOUT(16)) dut (
    .mclk, .resetn, .req_valid, .req_addr, .req_write, .req_mem, .req_be, .req_wdata,
    .disp_base, .disp_mask, .flash_base, .flash_mask, .req_ready, .rsp_done, .rsp_timeout,
    .rsp_rdata, .expansion_double_osc, .bus_clk_out, .sa_out, .sa_lo_oe, .sa_lo_in,
    .dma_addr, .la_out, .sbhe_n, .sd_out, .sd_oe, .sd_in, .dma_active,
    .periph_cycle_start_n, .periph_write_not_read, .periph_mem_not_io, .periph_cmd_n,
    .periph_ready_n, .display_region_select_n, .flash_disk_select_n, .boot_rom_select_n,
    .boot_rom_width_strap, .memr_n, .memw_n, .ior_n, .iow_n, .memcs16_n, .iocs16_n,
    .zero_wait_request_n);
  psb_far_model far (.mclk, .resetn, .periph_cmd_n, .periph_write_not_read, .ready_dly,
    .ready_off, .read_word, .periph_ready_n, .sd_in);
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // One clock step; bus clock rises are counted only while act is set
  task automatic tick;
    @(posedge mclk);
    #1;
    if (act && pb === 1'b0 && bus_clk_out === 1'b1) n_rise++;
    pb = bus_clk_out;
  endtask : tick
  // One request, held until done, noting what the bus showed meanwhile
  task automatic run(input logic [23:0] a, input logic wr, input logic mem,
                     input logic [1:0] be, input logic [15:0] wd);
    repeat (4) @(posedge mclk);
    req_addr <= a;
    req_write <= wr;
    req_mem <= mem;
    req_be <= be;
    req_wdata <= wd;
    req_valid <= 1'b1;
    {s_start, s_wr, s_mem, s_disp, s_flash, s_rom, s_sbhe, s_sd, s_nsel} = 9'h000;
    s_strb = 4'hF;
    s_addr = 24'h000000;
    {n_rise, act} = 0;
    for (int k = 0; k < 3000 && rsp_done !== 1'b1; k++) begin
      tick();
      act = ((memr_n & memw_n & ior_n & iow_n) === 1'b0);
      if (boot_rom_select_n === 1'b0) s_rom = 1'b1;
      if ((periph_cmd_n === 1'b0 || act) && sd_oe === 1'b1 && sd_out === wd) s_sd = 1'b1;
      if (act) s_strb = {memr_n, memw_n, ior_n, iow_n};
      // Expansion cycles must leave both peripheral-bus selects idle
      if (act && (flash_disk_select_n & display_region_select_n) !== 1'b1) s_nsel = 1'b1;
      if (periph_cycle_start_n === 1'b0) begin
        s_addr = {la_out, sa_out[16:0]};
        {s_start, s_wr, s_mem} = {1'b1, periph_write_not_read, periph_mem_not_io};
        {s_disp, s_flash, s_sbhe} = {display_region_select_n, flash_disk_select_n, sbhe_n};
      end
    end
    req_valid <= 1'b0;
    if (rsp_done !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask : run
  task automatic pi_read;
    read_word <= 16'hA55A;
    ready_dly <= 4'h3;
    run(24'h0A1234, 1'b0, 1'b1, 2'h3, 16'h0000);
    check({s_start, s_wr, s_mem, s_disp, s_flash, s_sbhe}, 6'h2A);
    check(s_addr, 24'h0A1234);
    check(rsp_rdata, 16'hA55A);
    check(rsp_timeout, 1'b0);
  endtask : pi_read
  task automatic pi_write;
    ready_dly <= 4'h0;
    run(24'hD00010, 1'b1, 1'b1, 2'h1, 16'h3C96);
    check({s_start, s_wr, s_mem, s_disp, s_flash, s_sbhe}, 6'h3D);
    check(s_addr, 24'hD00010);
    check(s_sd, 1'b1);
  endtask : pi_write
  // Silent peripheral: only the timeout may end the cycle
  task automatic pi_timeout;
    ready_off <= 1'b1;
    run(24'h0A0002, 1'b0, 1'b1, 2'h1, 16'h0000);
    check(rsp_timeout, 1'b1);
    tick();
    check(req_ready, 1'b1);
    ready_off <= 1'b0;
  endtask : pi_timeout
  // ROM with both straps and zero-wait, then 8-bit and 16-bit I/O
  task automatic isa_len;
    logic [2:0] len [6] = '{3'h3, 3'h2, 3'h6, 3'h3, 3'h6, 3'h2};
    for (int i = 0; i < 6; i++) begin
      boot_rom_width_strap <= (i < 2);
      iocs16_n <= (i != 5);
      zero_wait_request_n <= !i[0];
      run((i < 4) ? 24'h0F8000 : 24'h000300, 1'b0, (i < 4), 2'h1, 16'h0000);
      check(n_rise, len[i]);
      check(s_rom, (i < 4));
      check(s_strb, (i < 4) ? 4'h7 : 4'hD);
      check(s_nsel, 1'b0);
    end
  endtask : isa_len
  // 16-bit memory write by select, then 8-bit I/O write, both at full length
  task automatic isa_write;
    for (int i = 0; i < 2; i++) begin
      memcs16_n <= (i != 0);
      iocs16_n <= 1'b1;
      zero_wait_request_n <= 1'b1;
      run((i == 0) ? 24'h0C0000 : 24'h000310, 1'b1, (i == 0), 2'h3, 16'hBEEF);
      check(n_rise, (i == 0) ? 24'h3 : 24'h6);
      check(s_strb, (i == 0) ? 4'hB : 4'hE);
      check(s_sd, 1'b1);
      check(s_nsel, 1'b0);
      check(s_rom, 1'b0);
    end
  endtask : isa_write
  // 200 main clocks hold exactly 20 bus clock periods
  task automatic bus_rate;
    {n_rise, act} = 1;
    repeat (200) tick();
    check(n_rise, 20);
    act = 1'b0;
  endtask : bus_rate
  task automatic dma_in;
    dma_active <= 1'b1;
    sa_lo_in <= 17'h1A5C3;
    repeat (6) tick();
    check({sa_lo_oe, dma_addr}, 18'h1A5C3);
    dma_active <= 1'b0;
    sa_lo_in <= 17'h05A3C;
    repeat (4) tick();
    check(sa_lo_oe, 1'b1);
  endtask : dma_in
  initial begin
    repeat (10) @(posedge mclk);
    check(sd_oe, 1'b0);
    resetn <= 1'b1;
    pi_read();
    pi_write();
    pi_timeout();
    isa_len();
    isa_write();
    bus_rate();
    dma_in();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
